// ---- dv/ring_host_model.sv ----
// Host-side register master for the ring-buffer DMA manager
`timescale 1ns/1ps
module ring_host_model (
    // Clock and answer
    input wire logic i_core_clk,
    input wire logic i_ack,
    input wire logic [63:0] i_rdata,
    // Register requests
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [63:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'hff;
        o_wdata = 64'h0;
    end
    // Request held until the answer is seen at a rising edge or 8 rising edges pass, then released at the next falling edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [63:0] d,
                        output logic [63:0] q, output logic k);
        int n;
        @(negedge i_core_clk);
        o_wr = w;
        o_rd = !w;
        o_addr = a;
        o_wdata = d;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (i_ack !== 1'b1 && n < 8);
        q = i_rdata;
        k = i_ack;
        @(negedge i_core_clk);
        o_wr = 1'b0;
        o_rd = 1'b0;
        // Released lines show a changed pattern
        o_addr = ~a;
        o_wdata = ~d;
    endtask : xfer
endmodule : ring_host_model

// ---- dv/tb_ring_dma_output_buffering.sv ----
// Self-checking bench for the ring-buffer DMA manager
`timescale 1ns/1ps
`include "ring_dma_consts.svh"
module tb_ring_dma_output_buffering;
    import ring_dma_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr, rd, ack, beat, underrun, ready, wait_done, k;
    logic [7:0] addr;
    logic [63:0] wdata, rdata, q, card_pos, hw_size, total;
    len_t beat_bytes, fill;
    integer fails = 0, cmp_count = 0, seed = 32'h3811afed, i, j;
    integer done_count = 0, done_base;
    longint len = 64'h4000, ntf = 64'h1000, ulen, upos, clen, cpos, acc, b;
    always #20 clk = ~clk;
    ring_dma_output_buffering ring_dma_output_buffering_inst (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_clk_en(1'b1),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_ack(ack), .i_dma_beat(beat),
        .i_dma_beat_bytes(beat_bytes), .i_onboard_fill(fill), .i_underrun(underrun),
        .o_dma_ready(ready), .o_card_pos(card_pos), .o_hw_buf_size(hw_size),
        .o_total_buffer_bytes(total), .o_wait_done(wait_done));
    ring_host_model ring_host_model_inst (
        .i_core_clk(clk), .i_ack(ack), .i_rdata(rdata),
        .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    // Wait pulses, counted while they stand
    always @(negedge clk) if (wait_done === 1'b1) done_count++;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic wr_reg(input logic [7:0] a, input logic [63:0] d);
        ring_host_model_inst.xfer(1'b1, a, d, q, k);
        if (k !== 1'b1) begin
            fails++;
            $display("BAD %0t no bus answer", $time);
            summarize();
        end
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        ring_host_model_inst.xfer(1'b0, a, 64'h0, q, k);
        if (k !== 1'b1) begin
            fails++;
            $display("BAD %0t no bus answer", $time);
            summarize();
        end
    endtask : rd_reg
    task automatic commit_size(input logic [63:0] s, input logic [63:0] exp);
        wr_reg(`OFS_HW_OUT_BUF_SIZE, s);
        wr_reg(`OFS_COMMAND, 64'h1);
        @(negedge clk);
        chk(hw_size, exp);
        chk(total, exp + `OUT_FIFO_BYTES);
    endtask : commit_size
    task automatic do_beat(input longint n);
        @(negedge clk);
        beat = 1'b1;
        beat_bytes = n;
        @(negedge clk);
        beat = 1'b0;
        beat_bytes = ~beat_bytes;
        if (n <= clen) begin
            clen -= n;
            cpos = (cpos + n) % len;
            acc += n;
            if (acc >= ntf) begin
                ulen += ntf;
                acc -= ntf;
            end
        end
        @(negedge clk);
        chk(card_pos, cpos);
    endtask : do_beat
    task automatic wait_cmd;
        done_base = done_count;
        wr_reg(`OFS_COMMAND, 64'h4);
        for (i = 0; i < 50 && done_count == done_base; i++) @(negedge clk);
        chk(done_count - done_base, 64'h1);
        if (done_count == done_base) summarize();
    endtask : wait_cmd
    initial begin
        beat = 1'b0;
        beat_bytes = '0;
        fill = '0;
        underrun = 1'b0;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        chk(hw_size, `ONBOARD_MEM_BYTES);
        rd_reg(`OFS_HW_OUT_BUF_SIZE);
        chk(q, `ONBOARD_MEM_BYTES);
        wr_reg(`OFS_CARD_MODE, 64'h1);
        commit_size(64'h600, `ONBOARD_MEM_BYTES);
        commit_size(64'h200, `ONBOARD_MEM_BYTES);
        commit_size(64'h800_0000, `ONBOARD_MEM_BYTES);
        for (j = 0; j < 17; j++) commit_size(64'h400 << j, 64'h400 << j);
        wr_reg(`OFS_BUF_LENGTH, len);
        wr_reg(`OFS_NOTIFY_SIZE, ntf);
        wr_reg(`OFS_CARD_RELEASE_LEN, len);
        wr_reg(`OFS_COMMAND, 64'h2);
        ulen = 0;
        upos = 0;
        clen = len;
        cpos = 0;
        acc = 0;
        fill = hw_size - 64'h1;
        rd_reg(`OFS_USER_AVAIL_LEN);
        chk(q, 64'h0);
        chk(card_pos, 64'h0);
        chk(ready, 1'b1);
        fill = hw_size;
        repeat (2) @(negedge clk);
        chk(ready, 1'b0);
        fill = {$random(seed)} % 64'h400;
        repeat (4) begin
            for (j = 0; j < 40 && ulen < ntf; j++) do_beat(({$random(seed)} % ntf) + 1);
            repeat (3) do_beat(({$random(seed)} % ntf) + 1);
            wait_cmd();
            rd_reg(`OFS_USER_AVAIL_LEN);
            chk(q, ulen);
            rd_reg(`OFS_USER_AVAIL_POS);
            chk(q, upos);
            b = ulen - (({$random(seed)} % 2) * (ulen >= 2 * ntf) * ntf);
            wr_reg(`OFS_CARD_RELEASE_LEN, b);
            ulen -= b;
            clen += b;
            upos = (upos + b) % len;
            rd_reg(`OFS_USER_AVAIL_POS);
            chk(q, upos);
        end
        underrun = 1'b1;
        @(negedge clk);
        underrun = 1'b0;
        @(negedge clk);
        chk(ready, 1'b0);
        rd_reg(`OFS_STATUS);
        chk(q[`STS_UNDERRUN_BIT], 1'b1);
        wait_cmd();
        summarize();
    end
endmodule : tb_ring_dma_output_buffering

// ---- src/ring_dma_consts.svh ----
// Offsets, field positions, reset values and sizes of the ring-buffer DMA manager
`ifndef RING_DMA_CONSTS_SVH
`define RING_DMA_CONSTS_SVH
`define OFS_USER_AVAIL_LEN 8'hc8
`define OFS_USER_AVAIL_POS 8'hc9
`define OFS_CARD_RELEASE_LEN 8'hca
`define OFS_HW_OUT_BUF_SIZE 8'hd1
`define OFS_COMMAND 8'h10
`define OFS_CARD_MODE 8'h11
`define OFS_BUF_LENGTH 8'h12
`define OFS_NOTIFY_SIZE 8'h13
`define OFS_STATUS 8'h14
`define CMD_COMMIT_SETUP_BIT 0
`define CMD_DMA_START_BIT 1
`define CMD_DMA_WAIT_BIT 2
`define CMD_DMA_STOP_BIT 3
`define STS_RUNNING_BIT 0
`define STS_UNDERRUN_BIT 1
`define STS_WAITING_BIT 2
`define ONBOARD_MEM_BYTES 64'h0000_0000_0400_0000
`define HW_BUF_MIN_BYTES 64'h0000_0000_0000_0400
`define OUT_FIFO_BYTES 64'h0000_0000_0000_4000
`define NOTIFY_RESET 64'h0000_0000_0000_1000
`define BUF_LENGTH_RESET 64'h0000_0000_0001_0000
`endif

// ---- src/ring_dma_output_buffering.sv ----
// Ring-buffer DMA manager with programmable on-board output buffering
//
// Notes on behaviour
// - Each crossed notify boundary announces another block
// - Release advances user position past released region
// - Positions wrap to zero at buffer length
// - Available length counts both wrapped portions
// - Wait completes on one block or error
// - Exchange runs forever while host keeps pace
// - Hardware buffer size defaults to installed memory
// - Hardware size: powers of two, 1k to memory
// - Output FIFO fixed at 16 kByte
// - At start: user zero, card full length
// - Underrun stops transfer and flags status
`timescale 1ns/1ps
`include "ring_dma_consts.svh"
module ring_dma_output_buffering (
    // Clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    // Register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire ring_dma_pkg::reg_addr_t i_reg_addr,
    input wire ring_dma_pkg::len_t i_reg_wdata,
    output logic [63:0] o_reg_rdata,
    output logic o_reg_ack,
    // DMA engine and on-board memory
    input wire logic i_dma_beat,
    input wire ring_dma_pkg::len_t i_dma_beat_bytes,
    input wire ring_dma_pkg::len_t i_onboard_fill,
    input wire logic i_underrun,
    output logic o_dma_ready,
    output logic [63:0] o_card_pos,
    output logic [63:0] o_hw_buf_size,
    output logic [63:0] o_total_buffer_bytes,
    output logic o_wait_done
);
    import ring_dma_pkg::*;

    function automatic len_t wrap_add(input len_t pos, input len_t amt, input len_t len);
        len_t sum;
        sum = pos + amt;
        wrap_add = (sum >= len) ? sum - len : sum;
    endfunction : wrap_add

    function automatic logic size_ok(input len_t s);
        size_ok = (s != 64'h0) && ((s & (s - 64'h1)) == 64'h0)
            && (s >= `HW_BUF_MIN_BYTES) && (s <= `ONBOARD_MEM_BYTES);
    endfunction : size_ok

    run_state_e state_q, state_d;
    len_t user_len_q, user_len_d;
    len_t user_pos_q, user_pos_d;
    len_t card_len_q, card_len_d;
    len_t card_pos_q, card_pos_d;
    len_t acc_q, acc_d;
    len_t buf_len_q, notify_q;
    len_t hw_size_req_q, hw_size_q;
    len_t card_mode_q;
    logic underrun_q, waiting_q, wait_done_q;
    logic [63:0] rdata_q;
    logic ack_q, dma_ready_q;
    len_t total_q;

    // A strobe still held while its answer stands is the same request
    wire wr_take = i_reg_wr && !ack_q;
    wire rd_take = i_reg_rd && !ack_q;

    // Register decode
    wire wr_release = wr_take && (i_reg_addr == `OFS_CARD_RELEASE_LEN);
    wire wr_cmd = wr_take && (i_reg_addr == `OFS_COMMAND);
    wire cmd_commit = wr_cmd && i_reg_wdata[`CMD_COMMIT_SETUP_BIT];
    wire cmd_start = wr_cmd && i_reg_wdata[`CMD_DMA_START_BIT];
    wire cmd_wait = wr_cmd && i_reg_wdata[`CMD_DMA_WAIT_BIT];
    wire cmd_stop = wr_cmd && i_reg_wdata[`CMD_DMA_STOP_BIT];
    wire wr_hw_size = wr_take && (i_reg_addr == `OFS_HW_OUT_BUF_SIZE);
    wire hw_size_valid = size_ok(i_reg_wdata);
    wire cfg_open = (state_q != ST_RUN);
    wire running = (state_q == ST_RUN);

    // Transfer bookkeeping
    wire release_ok = wr_release && (i_reg_wdata <= user_len_q);
    wire len_t rel_amt = release_ok ? i_reg_wdata : 64'h0;
    wire beat_ok = running && i_dma_beat && (i_dma_beat_bytes <= card_len_q);
    wire len_t beat_amt = beat_ok ? i_dma_beat_bytes : 64'h0;
    wire len_t acc_sum = acc_q + beat_amt;
    wire crossed = (acc_sum >= notify_q);
    wire len_t block_amt = crossed ? notify_q : 64'h0;
    wire error_now = (state_q == ST_HALTED) || underrun_q;
    wire wait_met = (user_len_q >= notify_q) || error_now;

    always_comb begin
        state_d = state_q;
        user_len_d = user_len_q + block_amt - rel_amt;
        user_pos_d = wrap_add(user_pos_q, rel_amt, buf_len_q);
        card_len_d = card_len_q - beat_amt + rel_amt;
        card_pos_d = wrap_add(card_pos_q, beat_amt, buf_len_q);
        acc_d = acc_sum - block_amt;
        unique case (state_q)
            ST_IDLE: begin
                if (cmd_start) begin
                    state_d = ST_RUN;
                    user_len_d = 64'h0;
                    card_len_d = buf_len_q;
                    user_pos_d = 64'h0;
                    card_pos_d = 64'h0;
                    acc_d = 64'h0;
                end
            end
            ST_RUN: begin
                if (i_underrun) begin
                    state_d = ST_HALTED;
                end else if (cmd_stop) begin
                    state_d = ST_IDLE;
                end
            end
            ST_HALTED: begin
                if (cmd_stop) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Read mux
    wire [63:0] status_word = {61'h0, waiting_q, underrun_q, running};
    wire [63:0] rd_mux =
        (i_reg_addr == `OFS_USER_AVAIL_LEN) ? user_len_q :
        (i_reg_addr == `OFS_USER_AVAIL_POS) ? user_pos_q :
        (i_reg_addr == `OFS_HW_OUT_BUF_SIZE) ? hw_size_req_q :
        (i_reg_addr == `OFS_CARD_MODE) ? card_mode_q :
        (i_reg_addr == `OFS_BUF_LENGTH) ? buf_len_q :
        (i_reg_addr == `OFS_NOTIFY_SIZE) ? notify_q :
        (i_reg_addr == `OFS_STATUS) ? status_word : 64'h0;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            user_len_q <= 64'h0;
            user_pos_q <= 64'h0;
            card_len_q <= 64'h0;
            card_pos_q <= 64'h0;
            acc_q <= 64'h0;
        end else if (i_clk_en) begin
            state_q <= state_d;
            user_len_q <= user_len_d;
            user_pos_q <= user_pos_d;
            card_len_q <= card_len_d;
            card_pos_q <= card_pos_d;
            acc_q <= acc_d;
        end
    end

    // Configuration, only while not running
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hw_size_req_q <= `ONBOARD_MEM_BYTES;
            hw_size_q <= `ONBOARD_MEM_BYTES;
            card_mode_q <= 64'h0;
            buf_len_q <= `BUF_LENGTH_RESET;
            notify_q <= `NOTIFY_RESET;
            total_q <= `ONBOARD_MEM_BYTES + `OUT_FIFO_BYTES;
        end else if (i_clk_en && cfg_open) begin
            if (wr_hw_size && hw_size_valid) begin
                hw_size_req_q <= i_reg_wdata;
            end
            if (cmd_commit) begin
                hw_size_q <= hw_size_req_q;
                total_q <= hw_size_req_q + `OUT_FIFO_BYTES;
            end
            if (wr_take && (i_reg_addr == `OFS_CARD_MODE)) begin
                card_mode_q <= i_reg_wdata;
            end
            if (wr_take && (i_reg_addr == `OFS_BUF_LENGTH) && (i_reg_wdata != 64'h0)) begin
                buf_len_q <= i_reg_wdata;
            end
            if (wr_take && (i_reg_addr == `OFS_NOTIFY_SIZE) && (i_reg_wdata != 64'h0)) begin
                notify_q <= i_reg_wdata;
            end
        end
    end

    // Status, wait handshake, bus answer
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            underrun_q <= 1'b0;
            waiting_q <= 1'b0;
            wait_done_q <= 1'b0;
            rdata_q <= 64'h0;
            ack_q <= 1'b0;
            dma_ready_q <= 1'b0;
        end else if (i_clk_en) begin
            underrun_q <= (running && i_underrun)
                || (underrun_q && !(cmd_start && (state_q == ST_IDLE)));
            waiting_q <= (waiting_q || cmd_wait) && !wait_met;
            wait_done_q <= (waiting_q || cmd_wait) && wait_met;
            rdata_q <= rd_take ? rd_mux : 64'h0;
            ack_q <= rd_take || wr_take;
            // Follows the next state so an underrun drops it at once
            dma_ready_q <= (state_d == ST_RUN) && (card_len_d != 64'h0)
                && (i_onboard_fill < hw_size_q);
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_reg_ack = ack_q;
    assign o_dma_ready = dma_ready_q;
    assign o_card_pos = card_pos_q;
    assign o_hw_buf_size = hw_size_q;
    assign o_total_buffer_bytes = total_q;
    assign o_wait_done = wait_done_q;

    sequence s_start;
        i_clk_en && state_q == ST_IDLE && cmd_start;
    endsequence

    property p_start_counts;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        s_start |=> (user_len_q == 64'h0) && (card_len_q == buf_len_q) && running;
    endproperty
    a_start_counts: assert property (p_start_counts) else $error("start counts wrong");

    property p_release_pos;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        i_clk_en && release_ok && !(state_q == ST_IDLE && cmd_start)
        |=> user_pos_q == wrap_add($past(user_pos_q), $past(i_reg_wdata), buf_len_q);
    endproperty
    a_release_pos: assert property (p_release_pos) else $error("user position not advanced");

    property p_pos_in_range;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        running |-> (user_pos_q < buf_len_q) && (card_pos_q < buf_len_q);
    endproperty
    a_pos_in_range: assert property (p_pos_in_range) else $error("position not wrapped");

    property p_conserve;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        running |-> (user_len_q + card_len_q + acc_q) == buf_len_q;
    endproperty
    a_conserve: assert property (p_conserve) else $error("byte counts not conserved");

    property p_block_announce;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        i_clk_en && running && crossed && !release_ok
        |=> user_len_q == $past(user_len_q) + notify_q;
    endproperty
    a_block_announce: assert property (p_block_announce) else $error("block not announced");

    property p_wait_done;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        $rose(wait_done_q)
        |-> $past((user_len_q >= notify_q) || (state_q == ST_HALTED) || underrun_q);
    endproperty
    a_wait_done: assert property (p_wait_done) else $error("wait ended early");

    property p_underrun_stop;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        i_clk_en && running && i_underrun |=> state_q == ST_HALTED && underrun_q && !o_dma_ready;
    endproperty
    a_underrun_stop: assert property (p_underrun_stop) else $error("underrun not handled");

    property p_size_legal;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        size_ok(hw_size_req_q) && size_ok(hw_size_q);
    endproperty
    a_size_legal: assert property (p_size_legal) else $error("illegal hardware size");

    property p_bad_size_ignored;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        i_clk_en && wr_hw_size && !hw_size_valid |=> $stable(hw_size_req_q);
    endproperty
    a_bad_size_ignored: assert property (p_bad_size_ignored) else $error("bad size taken");

    property p_fifo_fixed;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        o_total_buffer_bytes - o_hw_buf_size == 64'h0000_0000_0000_4000;
    endproperty
    a_fifo_fixed: assert property (p_fifo_fixed) else $error("fifo depth changed");
endmodule : ring_dma_output_buffering

// ---- src/ring_dma_pkg.sv ----
// Types shared by the ring-buffer DMA manager
package ring_dma_pkg;
    typedef logic [63:0] len_t;
    typedef logic [7:0] reg_addr_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_HALTED = 2'b10
    } run_state_e;
endpackage : ring_dma_pkg
